// ### mtop_pkg.sv
// package: register map, encodings and timing for the motor overload block
package mtop_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FLA = 8'h04;
  localparam logic [7:0] A_SF = 8'h08;
  localparam logic [7:0] A_CLASS = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_NEED = 8'h14;
  localparam int CLS_RUN_LSB = 8;
  localparam int ST_TRIP_BIT = 8;
  localparam int ST_COOL_BIT = 9;
  localparam int ST_FAULT_BIT = 10;
  localparam int ST_RUN_BIT = 11;
  localparam int ST_CODE_LSB = 12;
  localparam logic [11:0] FLA_RST = 12'h000;
  localparam logic [7:0] SF_RST = 8'h64;
  localparam logic [4:0] CLS_RST = 5'h0A;
  localparam logic [4:0] CLS_MIN = 5'h05;
  localparam logic [4:0] CLS_MAX = 5'h1E;
  localparam logic [16:0] TH_FULL = 17'h1_9000;
  localparam logic [16:0] COOL_STEP = 17'h0_0011;
  localparam logic [6:0] HUNDRED = 7'h64;
  localparam logic [2:0] HEAT_SCREEN = 3'h4;
  localparam logic [8:0] THIRD_MUL = 9'h0AB;
  localparam int CLK_NS = 40;
  localparam int TICK_NS = 10_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int TICKS_PER_S = 1_000_000_000 / TICK_NS;
  localparam int TRIP_RATIO_SQ = 36;
  localparam logic [63:0] ENERGY_K = 64'(TRIP_RATIO_SQ * TICKS_PER_S);
  localparam int BLINK_TK = 25;
  localparam int N_SCR = 8;
  typedef enum logic [1:0] {
    OL_MANUAL = 2'b00,
    OL_AUTO = 2'b01,
    OL_OFF = 2'b10
  } mtop_mode_e;
  typedef enum logic [2:0] {
    D_STATUS = 3'b000,
    D_HEAT = 3'b001,
    D_NOFLA = 3'b010,
    D_INHIBIT = 3'b011,
    D_NO3PH = 3'b100
  } mtop_disp_e;
  typedef enum logic {
    S_IDLE = 1'b0,
    S_DIV = 1'b1
  } mtop_div_e;
endpackage

// ### mtop_overload.sv
// module: thermal overload model, trip/reset control, keypad display and ahb-lite registers
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
//Contract
//- zero full-load setting blocks start, shows fault
//- thermal register is remaining percent, 100 cool
//- thermal register restored from and saved nonvolatile
//- heating from full-load, service factor, classes
//- fourth screen up shows heat; screens wrap
//- overload mode may disable tripping entirely
//- manual default; trip blocks restart until reset
//- reset key held never prevents a trip
//- led solid when tripped, flashing once cooled
//- auto mode clears trip after cool-down
//- protection active on self-driven bypass
//- average last three start costs as needed
//- reset refused below needed capacity, shows inhibit
//- class n trips n seconds at 600%
//- start class until at-speed, then run class
//- start class limited to 5 through 30
//- run class only multiples of five
//- both classes reset to class ten
//- no line phases shows no-three-phase code
module mtop_overload #(
  parameter int TICK_CYCLES = mtop_pkg::TICK_CYC,
  parameter int BLINK_TICKS = mtop_pkg::BLINK_TK,
  parameter int N_SCREENS = mtop_pkg::N_SCR
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata_ff,
  output logic hreadyout_ff,
  output logic hresp_ff,
  input wire logic [12:0] motor_current,
  input wire logic at_speed,
  input wire logic bypass_closed,
  input wire logic bypass_self_driven,
  input wire logic [2:0] line_present,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  input wire logic key_reset,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic nvm_load,
  input wire logic [16:0] nvm_data,
  output logic nvm_store_ff,
  output logic [16:0] nvm_wdata_ff,
  output logic run_permit_ff,
  output logic ol_trip_ff,
  output logic ol_led_ff,
  output logic fault_ff,
  output logic [2:0] disp_code_ff,
  output logic [6:0] disp_value_ff,
  output logic [2:0] disp_screen_ff
);
  localparam int TCW = $clog2(TICK_CYCLES + 1);
  localparam int BCW = $clog2(BLINK_TICKS + 1);

  // the 64-step divide must finish before the next tick
  if (TICK_CYCLES < 70 || BLINK_TICKS < 1 || N_SCREENS < 5 || N_SCREENS > 8) begin : g_bad
    $error("mtop_overload: parameter out of range");
  end

  logic [1:0] mode_ff;
  logic [11:0] fla_ff;
  logic [7:0] sf_ff;
  logic [4:0] start_cls_ff;
  logic [4:0] run_cls_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [TCW-1:0] tick_cnt_ff;
  logic tick_ff;
  logic [16:0] th_ff;
  mtop_pkg::mtop_div_e div_st_ff;
  logic [6:0] div_cnt_ff;
  logic [63:0] dq_ff;
  logic [63:0] dr_ff;
  logic [63:0] dd_ff;
  logic [6:0] start_pct_ff;
  logic [6:0] hist_ff [3];
  logic [6:0] need_ff;
  logic at_d_ff;
  logic inh_ff;
  logic [BCW-1:0] blink_cnt_ff;
  logic blink_ff;

  logic addr_ph;
  logic [6:0] th_pct;
  logic [4:0] cur_cls;
  logic [19:0] fs;
  logic [19:0] i100;
  logic hot;
  logic prot_on;
  logic cool_ok;
  logic trip_set;
  logic trip_clr;
  logic [64:0] r2;
  logic [8:0] hsum;
  logic [6:0] used;

  assign addr_ph = hsel && hready && htrans[1];
  assign th_pct = th_ff[16:10];
  assign cur_cls = at_speed ? run_cls_ff : start_cls_ff;
  assign fs = 20'(fla_ff * sf_ff);
  assign i100 = 20'(motor_current * mtop_pkg::HUNDRED);
  assign hot = i100 > fs;
  // an across-the-line bypass not driven by us leaves the motor to external relays
  assign prot_on = mode_ff != mtop_pkg::OL_OFF && !(bypass_closed && !bypass_self_driven);
  assign cool_ok = th_ff != 17'h0_0000 && th_pct >= need_ff;
  assign trip_set = prot_on && th_ff == 17'h0_0000;
  assign trip_clr = ol_trip_ff && cool_ok &&
    ((mode_ff == mtop_pkg::OL_MANUAL && key_reset) || mode_ff == mtop_pkg::OL_AUTO);
  assign r2 = {dr_ff, dq_ff[63]};
  assign hsum = 9'(hist_ff[0]) + 9'(hist_ff[1]) + 9'(hist_ff[2]);
  assign used = start_pct_ff > th_pct ? 7'(start_pct_ff - th_pct) : 7'h00;

  function automatic logic run_cls_ok(input logic [4:0] c);
    run_cls_ok = c == 5'h05 || c == 5'h0A || c == 5'h0F || c == 5'h14 || c == 5'h19 || c == 5'h1E;
  endfunction

  // zero-wait slave: reads registered at the address phase, writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b0;
      hresp_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      wr_pend_ff <= addr_ph && hwrite;
      wr_addr_ff <= haddr;
      if (addr_ph && !hwrite) begin
        unique case (haddr)
          mtop_pkg::A_CTRL: hrdata_ff <= 32'(mode_ff);
          mtop_pkg::A_FLA: hrdata_ff <= 32'(fla_ff);
          mtop_pkg::A_SF: hrdata_ff <= 32'(sf_ff);
          mtop_pkg::A_CLASS: hrdata_ff <= 32'(start_cls_ff) | (32'(run_cls_ff) << mtop_pkg::CLS_RUN_LSB);
          mtop_pkg::A_STAT: hrdata_ff <= 32'(th_pct) | (32'(ol_trip_ff) << mtop_pkg::ST_TRIP_BIT) |
            (32'(cool_ok) << mtop_pkg::ST_COOL_BIT) | (32'(fault_ff) << mtop_pkg::ST_FAULT_BIT) |
            (32'(run_permit_ff) << mtop_pkg::ST_RUN_BIT) | (32'(disp_code_ff) << mtop_pkg::ST_CODE_LSB);
          mtop_pkg::A_NEED: hrdata_ff <= 32'(need_ff);
          default: hrdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // out-of-range class writes are dropped, so the classes can never leave their sets
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= mtop_pkg::OL_MANUAL;
      fla_ff <= mtop_pkg::FLA_RST;
      sf_ff <= mtop_pkg::SF_RST;
      start_cls_ff <= mtop_pkg::CLS_RST;
      run_cls_ff <= mtop_pkg::CLS_RST;
    end else if (wr_pend_ff) begin
      unique case (wr_addr_ff)
        mtop_pkg::A_CTRL: if (hwdata[1:0] != 2'b11) mode_ff <= hwdata[1:0];
        mtop_pkg::A_FLA: fla_ff <= hwdata[11:0];
        mtop_pkg::A_SF: sf_ff <= hwdata[7:0];
        mtop_pkg::A_CLASS: begin
          if (hwdata[4:0] >= mtop_pkg::CLS_MIN && hwdata[4:0] <= mtop_pkg::CLS_MAX) begin
            start_cls_ff <= hwdata[4:0];
          end
          if (run_cls_ok(hwdata[12:8])) run_cls_ff <= hwdata[12:8];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= tick_cnt_ff == TCW'(TICK_CYCLES - 1);
      tick_cnt_ff <= tick_cnt_ff == TCW'(TICK_CYCLES - 1) ? '0 : tick_cnt_ff + 1'b1;
    end
  end

  // per tick, heat = (i/fs)^2 * full / (class * 36 * ticks_per_s): class n empties in n s at 600%
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_st_ff <= mtop_pkg::S_IDLE;
      div_cnt_ff <= 7'h00;
      dq_ff <= 64'h0000_0000_0000_0000;
      dr_ff <= 64'h0000_0000_0000_0000;
      dd_ff <= 64'h0000_0000_0000_0001;
    end else begin
      unique case (div_st_ff)
        mtop_pkg::S_IDLE: if (tick_ff && hot && fla_ff != 12'h000) begin
          dq_ff <= 64'(i100) * 64'(i100) * 64'(mtop_pkg::TH_FULL);
          dd_ff <= 64'(fs) * 64'(fs) * 64'(cur_cls) * mtop_pkg::ENERGY_K;
          dr_ff <= 64'h0000_0000_0000_0000;
          div_cnt_ff <= 7'h00;
          div_st_ff <= mtop_pkg::S_DIV;
        end else if (div_cnt_ff == 7'h40) begin
          div_cnt_ff <= 7'h00; // quotient applied once, then cooling may resume
        end
        mtop_pkg::S_DIV: begin
          if (r2 >= 65'(dd_ff)) begin
            dr_ff <= 64'(r2 - 65'(dd_ff));
            dq_ff <= {dq_ff[62:0], 1'b1};
          end else begin
            dr_ff <= r2[63:0];
            dq_ff <= {dq_ff[62:0], 1'b0};
          end
          div_cnt_ff <= div_cnt_ff + 7'h01;
          if (div_cnt_ff == 7'h3F) div_st_ff <= mtop_pkg::S_IDLE;
        end
      endcase
    end
  end

  // restored value wins over the model; the saved copy keeps heat across a power cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      th_ff <= mtop_pkg::TH_FULL;
    end else if (nvm_load) begin
      th_ff <= nvm_data > mtop_pkg::TH_FULL ? mtop_pkg::TH_FULL : nvm_data;
    end else if (div_st_ff == mtop_pkg::S_IDLE && div_cnt_ff == 7'h40) begin
      th_ff <= dq_ff >= 64'(th_ff) ? 17'h0_0000 : 17'(th_ff - dq_ff[16:0]);
    end else if (tick_ff && !hot) begin
      th_ff <= th_ff > 17'(mtop_pkg::TH_FULL - mtop_pkg::COOL_STEP) ? mtop_pkg::TH_FULL :
        17'(th_ff + mtop_pkg::COOL_STEP);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nvm_store_ff <= 1'b0;
      nvm_wdata_ff <= mtop_pkg::TH_FULL;
    end else begin
      nvm_store_ff <= tick_ff && th_ff != nvm_wdata_ff;
      if (tick_ff) nvm_wdata_ff <= th_ff;
    end
  end

  // the trip set wins over every clear, so a held reset key cannot mask it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ol_trip_ff <= 1'b0;
    else if (trip_set) ol_trip_ff <= 1'b1;
    else if (trip_clr) ol_trip_ff <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_permit_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      if (trip_set || stop_cmd) run_permit_ff <= 1'b0;
      else if (start_cmd && fla_ff != 12'h000 && !ol_trip_ff && !fault_ff) run_permit_ff <= 1'b1;
      if (start_cmd && fla_ff == 12'h000) fault_ff <= 1'b1;
      else if (key_reset && fla_ff != 12'h000) fault_ff <= 1'b0;
    end
  end

  // a start counts once at-speed is reached; the divide-by-three is a multiply by 171/512
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      at_d_ff <= 1'b0;
      start_pct_ff <= 7'h00;
      hist_ff <= '{default: 7'h00};
      need_ff <= 7'h00;
    end else begin
      at_d_ff <= at_speed;
      if (start_cmd && !run_permit_ff) start_pct_ff <= th_pct;
      if (run_permit_ff && at_speed && !at_d_ff) begin
        hist_ff[0] <= used;
        hist_ff[1] <= hist_ff[0];
        hist_ff[2] <= hist_ff[1];
      end
      need_ff <= 7'((18'(hsum) * 18'(mtop_pkg::THIRD_MUL)) >> 9);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt_ff <= '0;
      blink_ff <= 1'b0;
      ol_led_ff <= 1'b0;
    end else begin
      if (tick_ff) begin
        blink_cnt_ff <= blink_cnt_ff == BCW'(BLINK_TICKS - 1) ? '0 : blink_cnt_ff + 1'b1;
        if (blink_cnt_ff == BCW'(BLINK_TICKS - 1)) blink_ff <= !blink_ff;
      end
      ol_led_ff <= ol_trip_ff && (!cool_ok || blink_ff);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_screen_ff <= 3'h0;
      inh_ff <= 1'b0;
    end else begin
      if (key_up) disp_screen_ff <= disp_screen_ff == 3'(N_SCREENS - 1) ? 3'h0 : disp_screen_ff + 3'h1;
      else if (key_down) disp_screen_ff <= disp_screen_ff == 3'h0 ? 3'(N_SCREENS - 1) : disp_screen_ff - 3'h1;
      if (key_reset && ol_trip_ff && !cool_ok && mode_ff == mtop_pkg::OL_MANUAL) inh_ff <= 1'b1;
      else if (!ol_trip_ff || key_up || key_down) inh_ff <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_code_ff <= mtop_pkg::D_STATUS;
      disp_value_ff <= 7'h00;
    end else begin
      disp_value_ff <= th_pct;
      if (fault_ff) disp_code_ff <= mtop_pkg::D_NOFLA;
      else if (inh_ff) disp_code_ff <= mtop_pkg::D_INHIBIT;
      else if (line_present == 3'b000) disp_code_ff <= mtop_pkg::D_NO3PH;
      else if (disp_screen_ff == mtop_pkg::HEAT_SCREEN) disp_code_ff <= mtop_pkg::D_HEAT;
      else disp_code_ff <= mtop_pkg::D_STATUS;
    end
  end

  a_nofla_fault: assert property (@(posedge hclk) disable iff (!hresetn)
    start_cmd && fla_ff == 12'h000 |=> fault_ff && !run_permit_ff ##1 disp_code_ff == mtop_pkg::D_NOFLA)
    else $error("start without full-load setting not faulted");
  a_th_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    th_ff <= mtop_pkg::TH_FULL)
    else $error("thermal register above full");
  a_trip_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    prot_on && th_ff == 17'h0_0000 && key_reset |=> ol_trip_ff)
    else $error("trip missed at zero capacity");
  a_off_notrip: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_ff == mtop_pkg::OL_OFF && !ol_trip_ff |=> !ol_trip_ff)
    else $error("trip while protection disabled");
  a_trip_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
    ol_trip_ff && !run_permit_ff && start_cmd |=> !run_permit_ff)
    else $error("restart allowed while tripped");
  a_led_solid: assert property (@(posedge hclk) disable iff (!hresetn)
    ol_trip_ff && !cool_ok |=> ol_led_ff)
    else $error("led not solid while hot");
  a_auto_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_ff == mtop_pkg::OL_AUTO && ol_trip_ff && cool_ok |=> !ol_trip_ff)
    else $error("auto reset did not clear trip");
  a_reset_inh: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_ff == mtop_pkg::OL_MANUAL && ol_trip_ff && !cool_ok && key_reset |=> ol_trip_ff && inh_ff)
    else $error("reset accepted below needed capacity");
  a_start_cls: assert property (@(posedge hclk) disable iff (!hresetn)
    start_cls_ff >= mtop_pkg::CLS_MIN && start_cls_ff <= mtop_pkg::CLS_MAX)
    else $error("start class out of range");
  a_run_cls: assert property (@(posedge hclk) disable iff (!hresetn)
    run_cls_ok(run_cls_ff))
    else $error("run class not allowed");
  a_screen_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    key_up && disp_screen_ff == 3'(N_SCREENS - 1) |=> disp_screen_ff == 3'h0)
    else $error("status screens do not wrap");
  a_no3ph_show: assert property (@(posedge hclk) disable iff (!hresetn)
    line_present == 3'b000 && !fault_ff && !inh_ff |=> disp_code_ff == mtop_pkg::D_NO3PH)
    else $error("no-three-phase code not shown");
endmodule // mtop_overload

// ### mtop_motor_model.sv
// motor current sensing and line supply model facing the overload block
`timescale 1ns/10ps
module mtop_motor_model #(
  parameter int SPD_DLY = 200
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run_permit,
  input wire logic [12:0] cur_cmd,
  input wire logic [2:0] line_cmd,
  input wire logic bypass_ext,
  output logic [12:0] motor_current,
  output logic at_speed,
  output logic bypass_closed,
  output logic bypass_self_driven,
  output logic [2:0] line_present
);
  int spd_cnt;
  // a stopped motor draws nothing, so sensed current follows the permit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      motor_current <= 13'h0000;
      line_present <= 3'h0;
      spd_cnt <= 0;
      at_speed <= 1'h0;
    end else begin
      motor_current <= run_permit ? cur_cmd : 13'h0000;
      line_present <= line_cmd;
      spd_cnt <= run_permit ? ((spd_cnt < SPD_DLY) ? spd_cnt + 1 : spd_cnt) : 0;
      at_speed <= run_permit && (spd_cnt >= SPD_DLY);
    end
  end
  // bypass closes at speed; bypass_ext marks an across-the-line bypass not driven by the starter
  assign bypass_closed = at_speed;
  assign bypass_self_driven = !bypass_ext;
endmodule // mtop_motor_model

// ### mtop_overload_bench.sv
// self-checking testbench for the motor overload block
`timescale 1ns/10ps
module mtop_overload_bench;
  localparam int TK = 100;
  localparam logic [4:0] K_START = 5'h10;
  localparam logic [4:0] K_STOP = 5'h08;
  localparam logic [4:0] K_RESET = 5'h04;
  localparam logic [4:0] K_UP = 5'h02;
  localparam logic [4:0] K_DOWN = 5'h01;
  typedef struct packed {logic [7:0] a; logic wr; logic [31:0] d; logic [31:0] e;} mtop_row_s;
  logic hclk, hresetn, hsel, hwrite, hreadyout_ff, hresp_ff, nvm_load, nvm_store_ff;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, line_present, line_cmd, disp_code_ff, disp_screen_ff;
  logic [31:0] hwdata, hrdata_ff, rd;
  logic [12:0] motor_current, cur_cmd;
  logic at_speed, bypass_closed, bypass_self_driven, run_permit_ff, ol_trip_ff, ol_led_ff, fault_ff, bypass_ext;
  logic [4:0] keys;
  logic [16:0] nvm_data, nvm_wdata_ff;
  logic [6:0] disp_value_ff;
  int fail_count, comparisons, n1;
  mtop_row_s rows [11] = '{
    '{8'h0C, 1'h0, 32'h0000_0000, 32'h0000_0A0A},
    '{8'h04, 1'h0, 32'h0000_0000, 32'h0000_0000},
    '{8'h08, 1'h0, 32'h0000_0000, 32'h0000_0064},
    '{8'h00, 1'h0, 32'h0000_0000, 32'h0000_0000},
    '{8'h10, 1'h0, 32'h0000_0000, 32'h0000_0264},
    '{8'h0C, 1'h1, 32'h0000_1E05, 32'h0000_1E05},
    '{8'h0C, 1'h1, 32'h0000_0C1F, 32'h0000_1E05},
    '{8'h0C, 1'h1, 32'h0000_1904, 32'h0000_1905},
    '{8'h0C, 1'h1, 32'h0000_0F0A, 32'h0000_0F0A},
    '{8'h00, 1'h1, 32'h0000_0003, 32'h0000_0000},
    '{8'h18, 1'h1, 32'h0000_00FF, 32'h0000_0000}
  };

  mtop_overload #(.TICK_CYCLES(TK), .BLINK_TICKS(2), .N_SCREENS(8)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout_ff), .hrdata_ff(hrdata_ff),
    .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .motor_current(motor_current),
    .at_speed(at_speed), .bypass_closed(bypass_closed), .bypass_self_driven(bypass_self_driven),
    .line_present(line_present), .start_cmd(keys[4]), .stop_cmd(keys[3]), .key_reset(keys[2]),
    .key_up(keys[1]), .key_down(keys[0]), .nvm_load(nvm_load), .nvm_data(nvm_data),
    .nvm_store_ff(nvm_store_ff), .nvm_wdata_ff(nvm_wdata_ff), .run_permit_ff(run_permit_ff),
    .ol_trip_ff(ol_trip_ff), .ol_led_ff(ol_led_ff), .fault_ff(fault_ff), .disp_code_ff(disp_code_ff),
    .disp_value_ff(disp_value_ff), .disp_screen_ff(disp_screen_ff));

  mtop_motor_model i_motor (
    .hclk(hclk), .hresetn(hresetn), .run_permit(run_permit_ff), .cur_cmd(cur_cmd), .line_cmd(line_cmd),
    .bypass_ext(bypass_ext),
    .motor_current(motor_current), .at_speed(at_speed), .bypass_closed(bypass_closed),
    .bypass_self_driven(bypass_self_driven), .line_present(line_present));

  initial begin
    hclk = 1'h0;
    forever #20 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // single word transfer; the request stands until hready is seen high
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout_ff !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout_ff !== 1'h1);
    r = hrdata_ff;
  endtask

  task automatic pulse(input logic [4:0] m);
    @(posedge hclk);
    keys <= m;
    @(posedge hclk);
    keys <= 5'h00;
    @(negedge hclk);
  endtask

  initial begin
    repeat (80000) @(posedge hclk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    hresetn = 1'h0; hsel = 1'h0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'h0; hsize = 3'h2;
    hwdata = 32'h0000_0000; keys = 5'h00; cur_cmd = 13'h0000; line_cmd = 3'h7;
    nvm_load = 1'h0; nvm_data = 17'h0_0000; fail_count = 0; comparisons = 0; bypass_ext = 1'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (3) @(negedge hclk);
    chk(32'(disp_value_ff), 32'h0000_0064);
    foreach (rows[i]) begin
      if (rows[i].wr) ahb(1'h1, rows[i].a, rows[i].d, rd);
      ahb(1'h0, rows[i].a, 32'h0000_0000, rd);
      chk(rd, rows[i].e);
    end
    // restored heat survives power loss: half capacity comes back as 50 percent
    @(posedge hclk);
    nvm_data <= 17'h0_C800;
    nvm_load <= 1'h1;
    @(posedge hclk);
    nvm_load <= 1'h0;
    repeat (3) @(negedge hclk);
    chk(32'(disp_value_ff), 32'h0000_0032);
    for (int n = 0; n < 2 * TK && nvm_store_ff !== 1'h1; n++) @(negedge hclk);
    chk(32'({nvm_store_ff, nvm_wdata_ff[16:10]}), 32'h0000_00B2);
    @(posedge hclk);
    nvm_data <= mtop_pkg::TH_FULL;
    nvm_load <= 1'h1;
    @(posedge hclk);
    nvm_load <= 1'h0;
    pulse(K_START);
    chk(32'({fault_ff, run_permit_ff}), 32'h0000_0002);
    @(negedge hclk);
    chk(32'(disp_code_ff), 32'(mtop_pkg::D_NOFLA));
    ahb(1'h1, mtop_pkg::A_FLA, 32'h0000_000A, rd);
    ahb(1'h1, mtop_pkg::A_CLASS, 32'h0000_0505, rd);
    pulse(K_RESET);
    chk(32'(fault_ff), 32'h0000_0000);
    repeat (4) pulse(K_UP);
    @(negedge hclk);
    chk(32'({disp_screen_ff, disp_code_ff, disp_value_ff}), 32'h0000_10E4);
    repeat (5) pulse(K_DOWN);
    chk(32'(disp_screen_ff), 32'h0000_0007);
    pulse(K_UP);
    chk(32'(disp_screen_ff), 32'h0000_0000);
    line_cmd <= 3'h0;
    repeat (4) @(negedge hclk);
    chk(32'(disp_code_ff), 32'(mtop_pkg::D_NO3PH));
    line_cmd <= 3'h7;
    repeat (4) @(negedge hclk);
    chk(32'(disp_code_ff), 32'(mtop_pkg::D_STATUS));
    // 600 percent on class 5 start/run: about 500 ticks to empty, reset key held throughout
    cur_cmd <= 13'h003C;
    @(posedge hclk);
    keys <= K_START | K_RESET;
    @(posedge hclk);
    keys <= K_RESET;
    repeat (480 * TK) @(negedge hclk);
    chk(32'(ol_trip_ff), 32'h0000_0000);
    for (int n = 0; n < 40 * TK && ol_trip_ff !== 1'h1; n++) @(negedge hclk);
    chk(32'(ol_trip_ff), 32'h0000_0001);
    @(posedge hclk);
    keys <= 5'h00;
    @(negedge hclk);
    chk(32'({run_permit_ff, ol_led_ff}), 32'h0000_0001);
    // register still empty until the next tick, so the reset is refused
    pulse(K_RESET);
    @(negedge hclk);
    chk(32'({ol_trip_ff, disp_code_ff}), 32'h0000_000B);
    pulse(K_START);
    chk(32'(run_permit_ff), 32'h0000_0000);
    repeat (2 * TK) @(negedge hclk);
    n1 = 0;
    repeat (8 * TK) begin
      @(negedge hclk);
      n1 += int'(ol_led_ff === 1'h1);
    end
    chk(32'(n1 > 0 && n1 < 8 * TK), 32'h0000_0001);
    pulse(K_RESET);
    chk(32'(ol_trip_ff), 32'h0000_0000);
    ahb(1'h1, mtop_pkg::A_CTRL, 32'h0000_0002, rd);
    pulse(K_START);
    repeat (20 * TK) @(negedge hclk);
    chk(32'({ol_trip_ff, run_permit_ff, disp_value_ff}), 32'h0000_0080);
    // an external across-the-line bypass suspends tripping even at zero capacity
    bypass_ext <= 1'h1;
    ahb(1'h1, mtop_pkg::A_CTRL, 32'h0000_0001, rd);
    repeat (4) @(negedge hclk);
    chk(32'(ol_trip_ff), 32'h0000_0000);
    bypass_ext <= 1'h0;
    for (int n = 0; n < 2 * TK && ol_trip_ff !== 1'h1; n++) @(negedge hclk);
    chk(32'(ol_trip_ff), 32'h0000_0001);
    for (int n = 0; n < 20 * TK && ol_trip_ff !== 1'h0; n++) @(negedge hclk);
    chk(32'(ol_trip_ff), 32'h0000_0000);
    pulse(K_START);
    chk(32'(run_permit_ff), 32'h0000_0001);
    pulse(K_STOP);
    chk(32'(run_permit_ff), 32'h0000_0000);
    // recorded start costs were 1 and 0 percent, so the average rounds to zero
    ahb(1'h0, mtop_pkg::A_NEED, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    chk(32'({hresp_ff, hreadyout_ff}), 32'h0000_0001);
    report_and_stop();
  end
endmodule // mtop_overload_bench
